// ==== core/program_memory_security.sv ====
// Purpose: on-chip program memory with lock bits, encryption and signature
// Assumes: programmer drives set-up mode, address and data via wishbone
// Notes: nonvolatile contents are modelled by flops; reset clears lock bits, erases the encryption array, leaves code
// Functional notes
// - an 8 Kbyte code array and a separate 64-byte encryption array are provided.
// - a 4-byte signature array is fixed at build time and can only be read.
// - every encryption byte reads ff until programmed.
// - verify picks the encryption byte by the low six code address bits.
// - verify returns the xnor of code byte and encryption byte.
// - level 1 has no locks, verify still encrypts, table reads are plain.
// - level 2 blocks table reads from external code into internal memory.
// - level 2 and up latch the external access pin at reset until next reset.
// - level 2 and up refuse further code programming.
// - level 3 adds a verify block to level 2.
// - level 4 adds a block on external execution to level 3.
// - program, verify and signature read only work in their set-up mode.
//
// Chosen here: the Wishbone register port and the address map.
module program_memory_security
  import prog_mem_pkg::*;
#(
  parameter int CODE_DEPTH = CODE_BYTES,
  parameter logic [31:0] SIGNATURE = 32'h5a3c_1e01 // value arbitrary
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic external_access_select_i,
  input wire logic code_table_read_instruction_i,
  input wire logic [CODE_AW-1:0] cpu_addr_i,
  output logic [7:0] cpu_data_o,
  output logic cpu_fetch_blocked_o,
  output logic ext_exec_o
);
  logic [7:0] code_mem [CODE_DEPTH];
  logic [2:0] mode_op;
  logic [CODE_AW-1:0] prog_addr;
  logic [7:0] data_out;
  logic refused;
  logic lock_bit_one;
  logic lock_bit_two;
  logic lock_bit_three;
  logic ea_s1;
  logic ea_s2;
  logic ea_latched;
  logic rst_seen;
  logic fetch_ext;
  logic [2:0] level;
  logic block_table_read;
  logic latch_ext;
  logic block_program;
  logic block_verify;
  logic block_ext_exec;
  logic [7:0] verify_byte;
  logic [7:0] code_rd;
  logic req;
  logic wr;
  logic hit;
  logic enc_we;
  logic ea_eff;
  setup_mode_e mode;

  function automatic setup_mode_e op_decode(input logic [2:0] op);
    case (op)
      3'h1: op_decode = OP_PROG_CODE;
      3'h2: op_decode = OP_VERIFY;
      3'h3: op_decode = OP_PROG_ENC;
      3'h4: op_decode = OP_PROG_LOCK;
      3'h5: op_decode = OP_READ_SIG;
      default: op_decode = OP_IDLE;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == REG_MODE) || (a == REG_ADDR) || (a == REG_DATA) ||
              (a == REG_STATUS) || (a == REG_LOCK) || (a == REG_CPU);
  endfunction

  assign mode = op_decode(mode_op);
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit = reg_hit(wb_adr_i);
  assign wr = req && hit && wb_we_i && wb_sel_i[0];
  assign code_rd = code_mem[prog_addr];

  security_level_decode u_level (
    .lock_bit_one_i(lock_bit_one),
    .lock_bit_two_i(lock_bit_two),
    .lock_bit_three_i(lock_bit_three),
    .level_o(level),
    .block_table_read_o(block_table_read),
    .latch_ext_o(latch_ext),
    .block_program_o(block_program),
    .block_verify_o(block_verify),
    .block_ext_exec_o(block_ext_exec)
  );

  assign enc_we = wr && wb_adr_i == REG_DATA && mode == OP_PROG_ENC && !block_program;

  encrypt_array u_enc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(enc_we),
    .waddr_i(prog_addr[ENC_AW-1:0]),
    .wdata_i(wb_dat_i[7:0]),
    .code_addr_i(prog_addr),
    .code_byte_i(code_rd),
    .verify_byte_o(verify_byte)
  );

  // bus handshake: registered ack with one wait state, error on unmapped address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_op <= MODE_RESET;
      prog_addr <= '0;
    end else if (wr && wb_adr_i == REG_MODE) begin
      mode_op <= wb_dat_i[MODE_OP_LSB +: MODE_OP_W];
    end else if (wr && wb_adr_i == REG_ADDR) begin
      prog_addr <= wb_dat_i[CODE_AW-1:0];
    end
  end

  // code array programming; bits only clear, like an otp cell
  always_ff @(posedge clk_i) begin
    if (wr && wb_adr_i == REG_DATA && mode == OP_PROG_CODE && !block_program) begin
      code_mem[prog_addr] <= code_mem[prog_addr] & wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused <= 1'b0;
    end else if (wr && wb_adr_i == REG_DATA) begin
      // only the two programming modes take data; signature is read only
      refused <= block_program || !(mode == OP_PROG_CODE || mode == OP_PROG_ENC);
    end else if (req && !wb_we_i && wb_adr_i == REG_DATA) begin
      refused <= (mode == OP_VERIFY && block_verify) || mode == OP_IDLE;
    end
  end

  // lock bits are sticky; they model fuses and survive only to reset here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_bit_one <= 1'b0;
      lock_bit_two <= 1'b0;
      lock_bit_three <= 1'b0;
    end else if (wr && wb_adr_i == REG_LOCK && mode == OP_PROG_LOCK) begin
      lock_bit_one <= lock_bit_one | wb_dat_i[0];
      lock_bit_two <= lock_bit_two | wb_dat_i[1];
      lock_bit_three <= lock_bit_three | wb_dat_i[2];
    end
  end

  // verify and signature data selection
  always_comb begin
    case (mode)
      OP_VERIFY: data_out = block_verify ? 8'h00 : verify_byte;
      OP_READ_SIG: data_out = SIGNATURE[8*prog_addr[1:0] +: 8];
      default: data_out = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        REG_MODE: wb_dat_o <= {29'h0, mode_op};
        REG_ADDR: wb_dat_o <= {19'h0, prog_addr};
        REG_DATA: wb_dat_o <= {24'h0, data_out};
        REG_STATUS: wb_dat_o <= {25'h0, level, 2'h0, ea_latched, refused};
        REG_LOCK: wb_dat_o <= {29'h0, lock_bit_three, lock_bit_two, lock_bit_one};
        REG_CPU: wb_dat_o <= {30'h0, ea_eff, fetch_ext};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // external access pin: synchronised, then caught once after reset
  // synchroniser runs through reset so the latch sees the real pin level
  always_ff @(posedge clk_i) begin
    ea_s1 <= external_access_select_i;
    ea_s2 <= ea_s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_seen <= 1'b0;
      ea_latched <= 1'b0;
    end else if (!rst_seen) begin
      rst_seen <= 1'b1;
      ea_latched <= ea_s2;
    end
  end

  assign ea_eff = latch_ext ? ea_latched : ea_s2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_ext <= 1'b0;
    end else begin
      fetch_ext <= !ea_eff && !block_ext_exec;
    end
  end

  // cpu side table read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_data_o <= 8'h00;
      cpu_fetch_blocked_o <= 1'b0;
    end else if (code_table_read_instruction_i && fetch_ext && block_table_read) begin
      cpu_data_o <= 8'h00;
      cpu_fetch_blocked_o <= 1'b1;
    end else begin
      cpu_data_o <= code_mem[cpu_addr_i];
      cpu_fetch_blocked_o <= 1'b0;
    end
  end

  assign ext_exec_o = fetch_ext;
endmodule

// ==== core/prog_mem_pkg.sv ====
// Purpose: shared constants for the program memory security block
// Assumes: 32-bit classic wishbone register bus, 10 MHz clock
// Notes: offsets are byte addresses of aligned words
package prog_mem_pkg;
  localparam int CODE_BYTES = 8192;
  localparam int CODE_AW = 13;
  localparam int ENC_BYTES = 64;
  localparam int ENC_AW = 6;
  localparam int SIG_BYTES = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // register offsets
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_LOCK = 8'h10;
  localparam logic [7:0] REG_CPU = 8'h14;
  // mode register field positions
  localparam int MODE_OP_LSB = 0;
  localparam int MODE_OP_W = 3;
  localparam logic [2:0] MODE_RESET = 3'h0;
  // status bit positions
  localparam int ST_REFUSED = 0;
  localparam int ST_EXT_LATCH = 1;
  localparam int ST_LEVEL_LSB = 4;
  // cpu register bit positions
  localparam int CPU_FETCH_EXT = 0;
  localparam int CPU_EXT_PIN = 1;
  typedef enum logic [5:0] {
    OP_IDLE = 6'b000001,
    OP_PROG_CODE = 6'b000010,
    OP_VERIFY = 6'b000100,
    OP_PROG_ENC = 6'b001000,
    OP_PROG_LOCK = 6'b010000,
    OP_READ_SIG = 6'b100000
  } setup_mode_e;
endpackage

// ==== core/security_level_decode.sv ====
// Purpose: turns the three lock bits into a security level and restriction set
// Assumes: lock bit value 1 means programmed
// Notes: highest programmed bit decides the level
module security_level_decode
  import prog_mem_pkg::*;
(
  input wire logic lock_bit_one_i,
  input wire logic lock_bit_two_i,
  input wire logic lock_bit_three_i,
  output logic [2:0] level_o,
  output logic block_table_read_o,
  output logic latch_ext_o,
  output logic block_program_o,
  output logic block_verify_o,
  output logic block_ext_exec_o
);
  always_comb begin
    if (lock_bit_three_i) begin
      level_o = 3'h4;
    end else if (lock_bit_two_i) begin
      level_o = 3'h3;
    end else if (lock_bit_one_i) begin
      level_o = 3'h2;
    end else begin
      level_o = 3'h1;
    end
  end
  assign block_table_read_o = (level_o >= 3'h2);
  assign latch_ext_o = (level_o >= 3'h2);
  assign block_program_o = (level_o >= 3'h2);
  assign block_verify_o = (level_o >= 3'h3);
  assign block_ext_exec_o = (level_o == 3'h4);
endmodule

// ==== core/encrypt_array.sv ====
// Purpose: 64-byte encryption array and verify byte scrambler
// Assumes: writes only arrive when allowed by the caller
// Notes: array starts erased at reset
module encrypt_array
  import prog_mem_pkg::*;
#(
  parameter int DEPTH = ENC_BYTES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [ENC_AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [CODE_AW-1:0] code_addr_i,
  input wire logic [7:0] code_byte_i,
  output logic [7:0] verify_byte_o
);
  logic [7:0] key [DEPTH];
  logic [7:0] sel;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_key
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          key[g] <= ERASED_BYTE;
        end else if (we_i && waddr_i == ENC_AW'(g)) begin
          key[g] <= key[g] & wdata_i; // programming only clears bits
        end
      end
    end
  endgenerate
  assign sel = key[code_addr_i[ENC_AW-1:0]];
  assign verify_byte_o = ~(code_byte_i ^ sel);
endmodule

// ==== test/pm_security_monitor.sv ====
// Purpose: port level checks of bus answers and table read blocking
// Assumes: single clock, synchronous active high reset
// Notes: bound to the block below the module
module pm_security_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic code_table_read_instruction_i,
  input wire logic [7:0] cpu_data_o,
  input wire logic cpu_fetch_blocked_o,
  input wire logic ext_exec_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  bus_answer_a: assert property (req |=> wb_ack_o ^ wb_err_o) else $error("no single answer");
  idle_quiet_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o) else $error("answer unasked");
  rdata_hold_a: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o)) else $error("rdata moved");
  blocked_zero_a: assert property (cpu_fetch_blocked_o |-> cpu_data_o == 8'h00) else $error("leak");
  blocked_cause_a: assert property (cpu_fetch_blocked_o |-> $past(code_table_read_instruction_i)) else $error("bad block");
  blocked_ext_a: assert property (cpu_fetch_blocked_o |-> ext_exec_o) else $error("block while internal");
  read_quiet_a: assert property (!code_table_read_instruction_i |=> !cpu_fetch_blocked_o) else $error("stray block");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ext_exec_o && !wb_ack_o && !cpu_fetch_blocked_o)
    else $error("outputs live in reset");
  cover property (cpu_fetch_blocked_o);
  cover property (wb_err_o);
  cover property (wb_ack_o && !wb_we_i);
endmodule

bind program_memory_security pm_security_checker checker_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .code_table_read_instruction_i(code_table_read_instruction_i), .cpu_data_o(cpu_data_o),
  .cpu_fetch_blocked_o(cpu_fetch_blocked_o), .ext_exec_o(ext_exec_o));

// ==== test/prog_model.sv ====
// Purpose: external programmer driving set-up modes over the register bus
// Assumes: classic single wishbone cycles
// Notes: released address and data show the inverse of the last value
module prog_model (
  input wire logic clk_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  input wire logic err_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cyc_o = 0;
    stb_o = 0;
    we_o = 0;
    adr_o = 0;
    sel_o = 0;
    dat_o = 0;
  end
  // one cycle; mode writes select the set-up mode before any access
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk_i);
    cyc_o <= 1;
    stb_o <= 1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do @(posedge clk_i); while (!(ack_i || err_i));
    q = dat_i;
    e = err_i;
    cyc_o <= 0;
    stb_o <= 0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the program memory security block
// Assumes: code bytes start unknown, so only zero is programmed into code
// Notes: signature byte n sits in bits 8n+7..8n
module testbench;
  import prog_mem_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] SIG = 32'h1234_5678; // value arbitrary
  logic clk_i = 0, rst_i = 1, ea = 0, tr = 0, cyc, stb, we, ack, err, blk, ext, e;
  logic [12:0] ca = 0;
  logic [7:0] adr, cd;
  logic [3:0] sel;
  logic [31:0] wd, rdat, q;
  int failures = 0, check_count = 0;
  program_memory_security #(.SIGNATURE(SIG)) program_memory_security_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .external_access_select_i(ea),
    .code_table_read_instruction_i(tr), .cpu_addr_i(ca), .cpu_data_o(cd), .cpu_fetch_blocked_o(blk),
    .ext_exec_o(ext));
  prog_model prog_i (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd),
    .dat_i(rdat), .ack_i(ack), .err_i(err));
  initial forever #50 clk_i = ~clk_i;
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    prog_i.xfer(1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a);
    prog_i.xfer(0, a, 0, q, e);
  endtask
  task table_read(input logic [12:0] a, input logic [7:0] d, input logic b);
    @(posedge clk_i);
    ca <= a;
    tr <= 1;
    @(posedge clk_i);
    tr <= 0;
    #1;
    check("table byte", cd, d);
    check("blocked", blk, b);
  endtask
  task do_reset;
    @(posedge clk_i);
    rst_i <= 1;
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
  endtask
  task t_open;
    rd(REG_STATUS);
    check("level", q[6:4], 1);
    prog_i.xfer(0, 8'hfc, 0, q, e);
    check("unmapped err", e, 1);
    // only bytes that are verified get programmed; the rest stay unused
    wr(REG_MODE, 1);
    wr(REG_ADDR, 'h45);
    wr(REG_DATA, 0);
    wr(REG_ADDR, 'h06);
    wr(REG_DATA, 0);
    wr(REG_MODE, 3);
    wr(REG_ADDR, 'h05);
    wr(REG_DATA, 'h5a);
    wr(REG_MODE, 2);
    wr(REG_ADDR, 'h45);
    rd(REG_DATA);
    check("verify xnor", q[7:0], 8'ha5);
    wr(REG_ADDR, 'h06);
    rd(REG_DATA);
    check("verify erased", q[7:0], 8'h00);
    table_read('h45, 8'h00, 0);
    wr(REG_MODE, 5);
    for (int i = 0; i < 4; i++) begin
      wr(REG_ADDR, i);
      rd(REG_DATA);
      check("signature", q[7:0], SIG[8*i+:8]);
    end
    wr(REG_DATA, 0);
    rd(REG_STATUS);
    check("sig write refused", q[0], 1);
    wr(REG_MODE, 0);
    rd(REG_DATA);
    check("idle data", q, 0);
    ea <= 1;
    repeat (5) @(posedge clk_i);
    rd(REG_CPU);
    check("live pin", q[1:0], 2'b10);
  endtask
  task t_locks;
    logic [2:0] lv [6] = '{1, 2, 4, 3, 6, 7};
    int ex [6] = '{2, 3, 4, 3, 4, 4};
    for (int i = 0; i < 6; i++) begin
      ea <= 0;
      do_reset;
      wr(REG_MODE, 4);
      wr(REG_LOCK, lv[i]);
      rd(REG_STATUS);
      check("lock level", q[6:4], ex[i]);
      wr(REG_MODE, 1);
      wr(REG_DATA, 0);
      rd(REG_STATUS);
      check("program refused", q[0], 1);
      wr(REG_MODE, 2);
      wr(REG_ADDR, 'h45);
      rd(REG_DATA);
      rd(REG_STATUS);
      check("verify refused", q[0], ex[i] >= 3);
      table_read('h45, 8'h00, ex[i] < 4);
      check("ext exec", ext, ex[i] < 4);
      ea <= 1;
      repeat (5) @(posedge clk_i);
      rd(REG_CPU);
      check("pin latched", q[1:0], {1'b0, ex[i] < 4});
    end
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    t_open;
    t_locks;
    tally_and_finish;
  end
endmodule
